//--- hw/bcrc_pkg.sv
// constants and types shared by the byte-stream checksum engine
package bcrc_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int unsigned BCRC_AW = 5;
    localparam int unsigned BCRC_DW = 32;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [BCRC_AW-1:0] OFS_CTRL = 5'h00;
    localparam logic [BCRC_AW-1:0] OFS_IN   = 5'h04;
    localparam logic [BCRC_AW-1:0] OFS_DAT  = 5'h08;
    localparam logic [BCRC_AW-1:0] OFS_FLIP = 5'h0c;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int unsigned CTRL_PNT_LSB  = 0;
    localparam int unsigned CTRL_VAL_BIT  = 2;
    localparam int unsigned CTRL_INIT_BIT = 3;
    localparam int unsigned CTRL_SEL_BIT  = 4;

    // ------------------------------------------------------------
    // algorithm constants
    // ------------------------------------------------------------
    localparam int unsigned BITS_PER_BYTE = 8;
    localparam logic [15:0] POLY16        = 16'h1021;
    localparam logic [31:0] POLY32        = 32'h04c11db7;
    // bit-reversed form of the 32-bit generator
    localparam logic [31:0] POLY32_REFL   = 32'hedb88320;
    localparam logic [31:0] INIT_ZERO     = 32'h00000000;
    localparam logic [31:0] INIT_ONES     = 32'hffffffff;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic        RST_SEL16  = 1'h0;
    localparam logic        RST_VAL    = 1'h0;
    localparam logic [1:0]  RST_PNT    = 2'h0;
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [31:0] RST_RESULT = INIT_ZERO;

    // ------------------------------------------------------------
    // wishbone request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic               cyc;
        logic               stb;
        logic               we;
        logic [BCRC_AW-1:0] adr;
        logic [3:0]         sel;
        logic [BCRC_DW-1:0] dat;
    } bcrc_wb_req_t;

endpackage : bcrc_pkg

//--- hw/bcrc_top.sv
// byte-stream crc16/crc32 engine with a classic wishbone register slave
//
// Added by the designer: the register addresses and the Wishbone register port.
module bcrc_top (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // wishbone slave
    input  wire bcrc_pkg::bcrc_wb_req_t wb_req,
    output logic                        wb_ack,
    output logic [bcrc_pkg::BCRC_DW-1:0] wb_rdata
);
    import bcrc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic               width_select_r;
    logic               init_value_select_r;
    logic [1:0]         result_byte_pointer_r;
    logic [7:0]         checksum_byte_input_r;
    logic [7:0]         bit_reverse_helper_r;
    logic [31:0]        result_r;
    logic               ack_r;
    logic [BCRC_DW-1:0] rdata_r;

    logic               width_select_nxt;
    logic               init_value_select_nxt;
    logic [1:0]         result_byte_pointer_nxt;
    logic [7:0]         checksum_byte_input_nxt;
    logic [7:0]         bit_reverse_helper_nxt;
    logic [31:0]        result_nxt;

    // ------------------------------------------------------------
    // checksum arithmetic
    // ------------------------------------------------------------
    function automatic logic [15:0] crc16_byte(
        input logic [15:0] acc,
        input logic [7:0]  din
    );
        logic [15:0] c;
        c = acc ^ {din, 8'h00};
        for (int i = 0; i < BITS_PER_BYTE; i++) begin
            if (c[15]) begin
                c = {c[14:0], 1'b0} ^ POLY16;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction : crc16_byte

    // reflected form: low byte in, right shifts, reversed generator
    function automatic logic [31:0] crc32_byte(
        input logic [31:0] acc,
        input logic [7:0]  din
    );
        logic [31:0] c;
        c = acc ^ {24'h000000, din};
        for (int i = 0; i < BITS_PER_BYTE; i++) begin
            if (c[0]) begin
                c = {1'b0, c[31:1]} ^ POLY32_REFL;
            end else begin
                c = {1'b0, c[31:1]};
            end
        end
        return c;
    endfunction : crc32_byte

    function automatic logic [7:0] rev8(input logic [7:0] b);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction : rev8

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // first cycle of a request latches read data and raises ack;
    // the ack cycle commits writes and pointer steps
    wire        req_first = wb_req.cyc & wb_req.stb & ~ack_r;
    wire        commit    = wb_req.cyc & wb_req.stb & ack_r;
    wire        lane0     = wb_req.sel[0];
    wire [7:0]  wbyte     = wb_req.dat[7:0];
    wire        hit_ctrl  = (wb_req.adr == OFS_CTRL);
    wire        hit_in    = (wb_req.adr == OFS_IN);
    wire        hit_dat   = (wb_req.adr == OFS_DAT);
    wire        hit_flip  = (wb_req.adr == OFS_FLIP);
    wire        wr_ok     = commit & wb_req.we & lane0;
    wire        wr_ctrl   = wr_ok & hit_ctrl;
    wire        wr_in     = wr_ok & hit_in;
    wire        wr_dat    = wr_ok & hit_dat;
    wire        wr_flip   = wr_ok & hit_flip;
    wire        rd_dat    = commit & ~wb_req.we & hit_dat;
    wire        acc_dat   = wr_dat | rd_dat;
    wire        init_wr   = wr_ctrl & wb_req.dat[CTRL_INIT_BIT];
    wire        init_ones = wb_req.dat[CTRL_VAL_BIT];

    // ------------------------------------------------------------
    // result datapath
    // ------------------------------------------------------------
    // 16-bit width folds only the low half and leaves the top alone
    wire [15:0] fold16   = crc16_byte(result_r[15:0], wbyte);
    wire [31:0] fold32   = crc32_byte(result_r, wbyte);
    wire [31:0] folded   = width_select_r ? {result_r[31:16], fold16} : fold32;
    wire [31:0] init_val = init_ones ? INIT_ONES : INIT_ZERO;
    // in 16-bit width codes 10 and 11 reach bytes 0 and 1 again
    wire [1:0]  win_idx  = width_select_r ? {1'b0, result_byte_pointer_r[0]}
                                          : result_byte_pointer_r;
    wire [4:0]  win_lsb  = {win_idx, 3'b000};
    wire [7:0]  win_byte = result_r[win_lsb +: 8];

    logic [31:0] win_merged;
    always_comb begin
        win_merged = result_r;
        win_merged[win_lsb +: 8] = wbyte;
    end

    always_comb begin
        if (init_wr) begin
            result_nxt = init_val;
        end else if (wr_in) begin
            result_nxt = folded;
        end else if (wr_dat) begin
            result_nxt = win_merged;
        end else begin
            result_nxt = result_r;
        end
    end

    // ------------------------------------------------------------
    // control and helper registers
    // ------------------------------------------------------------
    always_comb begin
        width_select_nxt        = width_select_r;
        init_value_select_nxt   = init_value_select_r;
        result_byte_pointer_nxt = result_byte_pointer_r;
        if (wr_ctrl) begin
            width_select_nxt        = wb_req.dat[CTRL_SEL_BIT];
            init_value_select_nxt   = init_ones;
            result_byte_pointer_nxt = wb_req.dat[CTRL_PNT_LSB +: 2];
        end else if (acc_dat) begin
            result_byte_pointer_nxt = result_byte_pointer_r + 2'h1;
        end
    end

    assign checksum_byte_input_nxt = wr_in ? wbyte : checksum_byte_input_r;
    assign bit_reverse_helper_nxt  = wr_flip ? rev8(wbyte) : bit_reverse_helper_r;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [7:0] ctrl_rd = {3'h0, width_select_r, 1'b0, init_value_select_r,
                          result_byte_pointer_r};
    wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                         hit_in   ? checksum_byte_input_r :
                         hit_dat  ? win_byte :
                         hit_flip ? bit_reverse_helper_r : 8'h00;
    wire [BCRC_DW-1:0] rd_word = {24'h000000, rd_byte};

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            width_select_r        <= RST_SEL16;
            init_value_select_r   <= RST_VAL;
            result_byte_pointer_r <= RST_PNT;
            checksum_byte_input_r <= RST_BYTE;
            bit_reverse_helper_r  <= RST_BYTE;
            result_r              <= RST_RESULT;
        end else begin
            width_select_r        <= width_select_nxt;
            init_value_select_r   <= init_value_select_nxt;
            result_byte_pointer_r <= result_byte_pointer_nxt;
            checksum_byte_input_r <= checksum_byte_input_nxt;
            bit_reverse_helper_r  <= bit_reverse_helper_nxt;
            result_r              <= result_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            ack_r   <= req_first;
            rdata_r <= req_first ? rd_word : rdata_r;
        end
    end

    assign wb_ack   = ack_r;
    assign wb_rdata = rdata_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [7:0] flip_raw_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            flip_raw_r <= RST_BYTE;
        end else if (wr_flip) begin
            flip_raw_r <= wbyte;
        end
    end

    a_crc16_vec_a: assert property (
        @(posedge clk) disable iff (rst)
        (wr_in && width_select_r && result_r[15:0] == 16'hffff && wbyte == 8'h63)
        |=> (result_r[15:0] == 16'hbd35))
        else $error("crc16 of 0x63 from ones is wrong");

    a_crc16_vec_b: assert property (
        @(posedge clk) disable iff (rst)
        (wr_in && width_select_r && result_r[15:0] == 16'hffff && wbyte == 8'h8c)
        |=> (result_r[15:0] == 16'hb1f4))
        else $error("crc16 of 0x8c from ones is wrong");

    a_crc32_vec_a: assert property (
        @(posedge clk) disable iff (rst)
        (wr_in && !width_select_r && result_r == INIT_ONES && wbyte == 8'h63)
        |=> (result_r == 32'hf9462090))
        else $error("crc32 of 0x63 from ones is wrong");

    a_init_load_value: assert property (
        @(posedge clk) disable iff (rst)
        init_wr |=> (result_r == ($past(init_ones) ? INIT_ONES : INIT_ZERO)))
        else $error("init strobe loaded wrong value");

    a_result_hold_idle: assert property (
        @(posedge clk) disable iff (rst)
        !(init_wr || wr_in || wr_dat) |=> $stable(result_r))
        else $error("result changed without an access");

    a_pointer_step_one: assert property (
        @(posedge clk) disable iff (rst)
        acc_dat |=> (result_byte_pointer_r == $past(result_byte_pointer_r) + 2'h1))
        else $error("pointer did not step by one");

    a_window_alias_16: assert property (
        @(posedge clk) disable iff (rst)
        (req_first && !wb_req.we && hit_dat && width_select_r)
        |=> (wb_rdata[7:0] ==
             ($past(result_byte_pointer_r[0]) ? result_r[15:8] : result_r[7:0])))
        else $error("16-bit window read wrong byte");

    a_flip_read_back: assert property (
        @(posedge clk) disable iff (rst)
        (req_first && !wb_req.we && hit_flip)
        |=> (wb_rdata == {24'h000000, flip_raw_r[0], flip_raw_r[1], flip_raw_r[2],
                          flip_raw_r[3], flip_raw_r[4], flip_raw_r[5], flip_raw_r[6],
                          flip_raw_r[7]}))
        else $error("flip readback not reversed");

    a_ack_one_cycle: assert property (
        @(posedge clk) disable iff (rst)
        wb_ack |=> !wb_ack)
        else $error("ack held longer than one cycle");

    a_crc16_vec_c: assert property (
        @(posedge clk) disable iff (rst)
        (wr_in && width_select_r && result_r[15:0] == 16'hffff && wbyte == 8'h7d)
        |=> (result_r[15:0] == 16'h4eca))
        else $error("crc16 of 0x7d from ones is wrong");

    a_fold16_upper_kept: assert property (
        @(posedge clk) disable iff (rst)
        (wr_in && width_select_r) |=> (result_r[31:16] == $past(result_r[31:16])))
        else $error("16-bit fold disturbed the upper half");

    a_no_lane_no_fold: assert property (
        @(posedge clk) disable iff (rst)
        (commit && wb_req.we && hit_in && !lane0) |=> $stable(result_r))
        else $error("input write without its lane changed the result");

    a_window_write_b0: assert property (
        @(posedge clk) disable iff (rst)
        (wr_dat && !width_select_r && result_byte_pointer_r == 2'h0)
        |=> (result_r[7:0] == $past(wbyte)))
        else $error("window write to byte 0 did not land");

    a_ack_after_req: assert property (
        @(posedge clk) disable iff (rst)
        req_first |=> wb_ack)
        else $error("request not acknowledged in the next cycle");

endmodule : bcrc_top

//--- test/bcrc_top_test.sv
// self-checking bench for the byte-stream checksum engine
module bcrc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import bcrc_pkg::*;

    // ------------------------------------------------------------
    // clock, reset and bus
    // ------------------------------------------------------------
    logic                 clk;
    logic                 rst;
    bcrc_wb_req_t         wb_req;
    logic                 wb_ack;
    logic [BCRC_DW-1:0]   wb_rdata;
    int                   fail_count  = 0;
    int                   check_count = 0;

    // ------------------------------------------------------------
    // vectors: bytes, counts, known results with all-ones start
    // ------------------------------------------------------------
    logic [7:0]  vb  [5][5] = '{'{8'h63, 8'h00, 8'h00, 8'h00, 8'h00},
                                '{8'haa, 8'hbb, 8'hcc, 8'h00, 8'h00},
                                '{8'h00, 8'h00, 8'haa, 8'hbb, 8'hcc},
                                '{8'h8c, 8'h00, 8'h00, 8'h00, 8'h00},
                                '{8'h7d, 8'h00, 8'h00, 8'h00, 8'h00}};
    int          vn  [5]    = '{1, 3, 5, 1, 1};
    logic [15:0] v16 [5]    = '{16'hbd35, 16'h6cf6, 16'hb166, 16'hb1f4, 16'h4eca};
    logic [31:0] v32 [3]    = '{32'hf9462090, 32'h41b207b3, 32'h78d129bc};

    bcrc_top u_bcrc_top (
        .clk      (clk),
        .rst      (rst),
        .wb_req   (wb_req),
        .wb_ack   (wb_ack),
        .wb_rdata (wb_rdata)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one classic cycle: hold until ack is sampled, then release
    task automatic xfer(input logic we, input logic [BCRC_AW-1:0] adr,
                        input logic [3:0] sel, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: {24'h0, d}};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
        end
        q = wb_rdata;
        wb_req <= '0;
    endtask : xfer

    task automatic wr(input logic [BCRC_AW-1:0] adr, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, adr, 4'h1, d, q);
    endtask : wr

    task automatic rd(input logic [BCRC_AW-1:0] adr, output logic [31:0] q);
        xfer(1'b0, adr, 4'h1, 8'h00, q);
    endtask : rd

    // four window reads starting from pointer 0
    task automatic rd_res(output logic [31:0] r);
        logic [31:0] q;
        for (int i = 0; i < 4; i++) begin
            rd(OFS_DAT, q);
            r[8*i +: 8] = q[7:0];
        end
    endtask : rd_res

    // reference fold of one byte
    function automatic logic [31:0] mdl(input logic m16, input logic [31:0] a,
                                        input logic [7:0] d);
        if (m16) begin
            a[15:8] ^= d;
            for (int i = 0; i < 8; i++) begin
                a[15:0] = a[15] ? ({a[14:0], 1'b0} ^ POLY16) : {a[14:0], 1'b0};
            end
        end else begin
            a[7:0] ^= d;
            for (int i = 0; i < 8; i++) begin
                a = a[0] ? ((a >> 1) ^ POLY32_REFL) : (a >> 1);
            end
        end
        return a;
    endfunction : mdl

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        #200000;
        fail_count++;
        end_sim();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic [31:0] r;
        logic [31:0] e;
        wb_req = '0;
        rst    = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_CTRL, q);
        chk(q, 32'h0);
        rd_res(r);
        chk(r, 32'h0);
        for (int m = 0; m < 2; m++) begin
            for (int v = 0; v < 2; v++) begin
                for (int k = 0; k < 5; k++) begin
                    wr(OFS_CTRL, {3'h0, m[0], 1'b1, v[0], 2'h0});
                    e = v[0] ? INIT_ONES : INIT_ZERO;
                    for (int j = 0; j < vn[k]; j++) begin
                        wr(OFS_IN, vb[k][j]);
                        e = mdl(m[0], e, vb[k][j]);
                    end
                    if (v[0] && m[0]) e[15:0] = v16[k];
                    if (v[0] && !m[0] && k < 3) e = v32[k];
                    rd_res(r);
                    if (m[0]) begin
                        chk({16'h0, r[15:0]}, {16'h0, e[15:0]});
                        chk({16'h0, r[31:16]}, {16'h0, e[15:0]});
                    end else begin
                        chk(r, e);
                    end
                    rd(OFS_CTRL, q);
                    chk(q, {27'h0, m[0], 1'b0, v[0], 2'h0});
                end
            end
        end
        // window writes load the result, then a byte folds in at once
        wr(OFS_CTRL, 8'h00);
        for (int i = 0; i < 4; i++) wr(OFS_DAT, 8'((i + 1) * 8'h11));
        wr(OFS_IN, 8'h63);
        rd_res(r);
        chk(r, mdl(1'b0, 32'h44332211, 8'h63));
        rd(OFS_IN, q);
        chk(q, 32'h63);
        // a write without its byte lane must not fold
        wr(OFS_CTRL, 8'h1c);
        xfer(1'b1, OFS_IN, 4'he, 8'h63, q);
        rd_res(r);
        chk({16'h0, r[15:0]}, 32'h0000ffff);
        // bit reverse helper
        wr(OFS_FLIP, 8'hc0);
        rd(OFS_FLIP, q);
        chk(q, 32'h03);
        wr(OFS_FLIP, 8'h05);
        rd(OFS_FLIP, q);
        chk(q, 32'ha0);
        // unmapped place reads zero
        wr(5'h10, 8'hff);
        rd(5'h10, q);
        chk(q, 32'h0);
        end_sim();
    end

endmodule : bcrc_top_test
